// [hdl/arp_pkg.sv]
// constants, codes and register map of the result read-out port
package arp_pkg;
  // ****************************************
  // data widths
  // ****************************************
  localparam int unsigned RES_W = 14;
  localparam int unsigned CH_W = 3;
  localparam int unsigned PIN_W = 16;
  localparam int unsigned FIFO_W = RES_W + CH_W;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned ADDR_W = 8;

  // ****************************************
  // register map (byte addresses) and fields
  // ****************************************
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_RESULT = 8'h08;
  localparam int unsigned RESULT_CH_LSB = 16;
  localparam logic [CNT_W-1:0] CONV_CYCLES_RST = 16'h0100;
  localparam logic [CH_W-1:0] FIRST_CH = 3'h0;

  // ****************************************
  // positions in the synchronised pin vector
  // ****************************************
  localparam int unsigned AI_RD = 0;
  localparam int unsigned AI_CS = 1;
  localparam int unsigned AI_D14 = 2;
  localparam int unsigned AI_D15 = 3;
  localparam int unsigned AI_PD = 4;
  localparam int unsigned AI_RANGE = 5;
  localparam int unsigned AI_OS = 6;
  localparam int unsigned AI_REF = 9;
  localparam int unsigned AI_RST = 10;
  localparam int unsigned AI_CVA = 11;
  localparam int unsigned AI_CVB = 12;
  localparam int unsigned AI_SEL = 13;
  localparam int unsigned AI_W = 15;

  // ****************************************
  // data pin positions
  // ****************************************
  localparam int unsigned PIN_SER_A = 7;
  localparam int unsigned PIN_SER_B = 8;
  localparam int unsigned PIN_HBEN = 14;
  localparam int unsigned PIN_BYTE = 15;

  typedef enum logic [1:0] {
    IF_WORD = 2'b00,
    IF_SERIAL = 2'b01,
    IF_BYTE = 2'b10
  } arp_if_mode_t;

  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'b00,
    PWR_STANDBY = 2'b01,
    PWR_SHUTDOWN = 2'b10
  } arp_pwr_t;
endpackage

// [hdl/arp_fifo_if.sv]
// result fifo carrier between the port logic and its buffer
interface arp_fifo_if #(
  parameter int unsigned W = 17,
  parameter int unsigned D = 8
);
  logic push_valid;
  logic push_ready;
  logic [W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [W-1:0] pop_data;
  logic flush;
  logic [$clog2(D+1)-1:0] level;
  modport store (
    input push_valid, push_data, pop_ready, flush,
    output push_ready, pop_valid, pop_data, level
  );
  modport user (
    output push_valid, push_data, pop_ready, flush,
    input push_ready, pop_valid, pop_data, level
  );
endinterface

// [hdl/arp_fifo.sv]
// result fifo with parameterised width and depth
module arp_fifo #(
  parameter int unsigned W = 17,
  parameter int unsigned D = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // fifo ports
  arp_fifo_if.store f
);
  localparam int unsigned PW = $clog2(D);
  localparam int unsigned CW = $clog2(D+1);
  localparam logic [PW-1:0] PTR_LAST = PW'(D - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(D);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);

  typedef struct packed {
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [CW-1:0] count;
  } arp_fifo_st_t;

  arp_fifo_st_t st;
  arp_fifo_st_t next_st;
  logic [W-1:0] mem [D];
  logic do_push;
  logic do_pop;

  assign f.push_ready = (st.count != CNT_FULL);
  assign f.pop_valid = (st.count != '0);
  assign f.pop_data = mem[st.rptr];
  assign f.level = st.count;
  assign do_push = f.push_valid && f.push_ready && !f.flush;
  assign do_pop = f.pop_ready && f.pop_valid && !f.flush;

  always_comb begin
    next_st = st;
    if (f.flush) begin
      next_st = '0;
    end else begin
      if (do_push) begin
        next_st.wptr = (st.wptr == PTR_LAST) ? '0 : st.wptr + 1'b1;
      end
      if (do_pop) begin
        next_st.rptr = (st.rptr == PTR_LAST) ? '0 : st.rptr + 1'b1;
      end
      if (do_push && !do_pop) begin
        next_st.count = st.count + CNT_ONE;
      end else if (do_pop && !do_push) begin
        next_st.count = st.count - CNT_ONE;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // memory has no reset: only words below the count are ever read
  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem[st.wptr] <= f.push_data;
    end
  end

  fifo_bound_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st.count <= CNT_FULL) else $error("fifo count above depth");
endmodule

// [hdl/arp_port.sv]
// result read-out port: pin logic, busy timer, power pins and apb registers
// Notes on behaviour
// - word mode: bits 3..13 on pins 5..15
// - byte mode: pins 5..7 carry 11..13 or 3..5
// - pin 14: bit 12, or byte select input
// - pin 15: bit 13, or byte mode enable input
// - serial mode: pins 7, 8 are serial outputs
// - marker high while channel 0 is read
// - range picks span, or standby versus shutdown
// - powerdown low enters standby or shutdown
// - reset pin high clears read-out, conversion logic and fifo
// - reference select drives internal reference out
// - word mode: pins 0,1 low, 2..4 bits 0..2
// - busy high while conversion runs
//
// The APB register port and the register addresses are this design's own decisions.
module arp_port
  import arp_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // host control pins
  input wire logic rd_sclk_n_i,
  input wire logic cs_n_i,
  input wire logic [1:0] interface_select_i,
  input wire logic conv_start_first_half_i,
  input wire logic conv_start_second_half_i,
  input wire logic powerdown_n_i,
  input wire logic range_i,
  input wire logic oversample_ctrl_0_i,
  input wire logic oversample_ctrl_1_i,
  input wire logic oversample_ctrl_2_i,
  input wire logic reference_select_i,
  input wire logic reset_i,
  // data pins, split into in, out and enable
  input wire logic [PIN_W-1:0] data_pin_i,
  output logic [PIN_W-1:0] data_pin_o,
  output logic [PIN_W-1:0] data_pin_oe_o,
  // status and analog control
  output logic first_channel_marker_o,
  output logic busy_o,
  output logic [1:0] power_state_o,
  output logic range_10v_o,
  output logic [2:0] oversample_o,
  output logic ref_internal_en_o,
  output logic reference_pin_oe_o
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [AI_W-1:0] s1;
    logic [AI_W-1:0] s2;
    logic [AI_W-1:0] prev;
    logic [CNT_W-1:0] conv_cycles;
    logic [CNT_W-1:0] busy_cnt;
    logic busy;
    arp_if_mode_t mode;
    logic [RES_W-1:0] hold;
    logic [CH_W-1:0] hold_ch;
    logic [RES_W-1:0] sh_a;
    logic [RES_W-1:0] sh_b;
    logic load_b;
    logic [PIN_W-1:0] pin_out;
    logic [PIN_W-1:0] pin_oe;
    logic marker;
    arp_pwr_t pwr;
    logic range_10v;
    logic [2:0] os;
    logic ref_en;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } arp_state_t;

  localparam logic [AI_W-1:0] PIN_IDLE = (AI_W'(1) << AI_RD) | (AI_W'(1) << AI_CS) |
    (AI_W'(1) << AI_PD);
  // strobes and powerdown start at their idle levels so no false edge follows reset
  localparam arp_state_t ST_RST = '{s1: PIN_IDLE, s2: PIN_IDLE, prev: PIN_IDLE,
    conv_cycles: CONV_CYCLES_RST, mode: IF_WORD, marker: 1'b1, pwr: PWR_ACTIVE, default: '0};
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

  arp_state_t st;
  arp_state_t next_st;
  logic [1:0] rst_sync;
  logic rst_n;
  logic [AI_W-1:0] pins_async;
  logic pop_ready;
  logic push_valid;
  logic [FIFO_W-1:0] push_data;

  arp_fifo_if #(.W(FIFO_W), .D(DEPTH)) fq ();

  arp_fifo #(.W(FIFO_W), .D(DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .f(fq.store)
  );

  // maps one result onto the parallel pins for word or byte access
  function automatic logic [PIN_W-1:0] pin_map(input logic [RES_W-1:0] r,
                                               input arp_if_mode_t m, input logic hi);
    logic [PIN_W-1:0] v;
    v = '0;
    if (m == IF_BYTE) begin
      v[7:0] = hi ? r[13:6] : {r[5:0], 2'b00};
    end else begin
      v = {r, 2'b00};
    end
    return v;
  endfunction

  assign pins_async = {interface_select_i, conv_start_second_half_i, conv_start_first_half_i,
    reset_i, reference_select_i, oversample_ctrl_2_i, oversample_ctrl_1_i,
    oversample_ctrl_0_i, range_i, powerdown_n_i, data_pin_i[PIN_BYTE],
    data_pin_i[PIN_HBEN], cs_n_i, rd_sclk_n_i};
  assign rst_n = rst_sync[1];
  assign fq.pop_ready = pop_ready;
  assign fq.push_valid = push_valid;
  assign fq.push_data = push_data;
  assign fq.flush = st.s2[AI_RST];

  // ****************************************
  // reset release
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic rd_fall;
    logic cs_fall;
    logic sclk_rise;
    logic drive;
    logic start;
    logic acc;
    logic ok;
    logic [RES_W-1:0] head;
    arp_if_mode_t sel;
    rd_fall = 1'b0;
    cs_fall = 1'b0;
    sclk_rise = 1'b0;
    drive = 1'b0;
    start = 1'b0;
    acc = 1'b0;
    ok = 1'b0;
    head = '0;
    sel = IF_WORD;
    next_st = st;
    pop_ready = 1'b0;
    next_st.s1 = pins_async;
    next_st.s2 = st.s1;
    next_st.prev = st.s2;
    head = fq.pop_data[RES_W-1:0];
    rd_fall = st.prev[AI_RD] && !st.s2[AI_RD] && !st.s2[AI_CS];
    cs_fall = st.prev[AI_CS] && !st.s2[AI_CS];
    sclk_rise = !st.prev[AI_RD] && st.s2[AI_RD] && !st.s2[AI_CS];
    unique case (st.s2[AI_SEL +: 2])
      2'b01: sel = IF_SERIAL;
      2'b10: sel = IF_BYTE;
      default: sel = IF_WORD;
    endcase
    next_st.mode = sel;
    // read-out data path
    unique case (sel)
      IF_SERIAL: begin
        drive = !st.s2[AI_CS];
        if (cs_fall && fq.pop_valid) begin
          pop_ready = 1'b1;
          next_st.sh_a = head;
          next_st.hold_ch = fq.pop_data[FIFO_W-1 -: CH_W];
          next_st.load_b = 1'b1;
        end else if (st.load_b) begin
          // second word follows one cycle later; an empty fifo shifts out zeros
          pop_ready = fq.pop_valid;
          next_st.sh_b = fq.pop_valid ? head : '0;
          next_st.load_b = 1'b0;
        end else if (sclk_rise) begin
          next_st.sh_a = {st.sh_a[RES_W-2:0], 1'b0};
          next_st.sh_b = {st.sh_b[RES_W-2:0], 1'b0};
        end
        next_st.pin_out = '0;
        next_st.pin_out[PIN_SER_A] = next_st.sh_a[RES_W-1];
        next_st.pin_out[PIN_SER_B] = next_st.sh_b[RES_W-1];
        next_st.pin_oe = '0;
        next_st.pin_oe[PIN_SER_A] = drive;
        next_st.pin_oe[PIN_SER_B] = drive;
      end
      IF_BYTE: begin
        // byte mode needs the host to hold pin 15 high as well
        drive = !st.s2[AI_CS] && !st.s2[AI_RD] && st.s2[AI_D15];
        if (rd_fall && st.s2[AI_D14] && fq.pop_valid) begin
          pop_ready = 1'b1;
          next_st.hold = head;
          next_st.hold_ch = fq.pop_data[FIFO_W-1 -: CH_W];
        end
        next_st.pin_out = pin_map(next_st.hold, IF_BYTE, st.s2[AI_D14]);
        next_st.pin_oe = {8'h00, {8{drive}}};
      end
      default: begin
        drive = !st.s2[AI_CS] && !st.s2[AI_RD];
        if (rd_fall && fq.pop_valid) begin
          pop_ready = 1'b1;
          next_st.hold = head;
          next_st.hold_ch = fq.pop_data[FIFO_W-1 -: CH_W];
        end
        next_st.pin_out = pin_map(next_st.hold, IF_WORD, 1'b0);
        next_st.pin_oe = {PIN_W{drive}};
      end
    endcase
    next_st.marker = (next_st.hold_ch == FIRST_CH);
    // conversion timer
    start = (st.s2[AI_CVA] && !st.prev[AI_CVA]) || (st.s2[AI_CVB] && !st.prev[AI_CVB]);
    if (start && !st.busy && st.pwr == PWR_ACTIVE) begin
      next_st.busy = 1'b1;
      next_st.busy_cnt = (st.conv_cycles == '0) ? CNT_ONE : st.conv_cycles;
    end else if (st.busy) begin
      next_st.busy_cnt = st.busy_cnt - CNT_ONE;
      next_st.busy = (st.busy_cnt != CNT_ONE);
    end
    // power, range, oversampling and reference pins
    if (st.s2[AI_PD]) begin
      next_st.pwr = PWR_ACTIVE;
      next_st.range_10v = st.s2[AI_RANGE];
    end else begin
      next_st.pwr = st.s2[AI_RANGE] ? PWR_SHUTDOWN : PWR_STANDBY;
    end
    next_st.os = st.s2[AI_OS +: 3];
    next_st.ref_en = st.s2[AI_REF];
    // apb slave: answer one cycle into the access phase, later for a result write while the fifo is full
    acc = psel_i && penable_i && !st.pready;
    next_st.pready = 1'b0;
    if (acc) begin
      unique case (paddr_i)
        REG_CTRL: begin
          ok = 1'b1;
          next_st.prdata = {16'h0000, st.conv_cycles};
          next_st.pslverr = 1'b0;
        end
        REG_STATUS: begin
          ok = 1'b1;
          next_st.prdata = {12'h000, 4'(fq.level), 4'h0, st.os, st.ref_en, 1'b0, st.range_10v,
                            st.pwr, st.mode, st.marker, st.busy};
          next_st.pslverr = 1'b0;
        end
        REG_RESULT: begin
          ok = !pwrite_i || fq.push_ready;
          next_st.prdata = '0;
          next_st.pslverr = 1'b0;
        end
        default: begin
          ok = 1'b1;
          next_st.prdata = '0;
          next_st.pslverr = 1'b1;
        end
      endcase
      next_st.pready = ok;
    end
    if (psel_i && penable_i && st.pready && pwrite_i && paddr_i == REG_CTRL) begin
      next_st.conv_cycles = pwdata_i[CNT_W-1:0];
    end
    // reset pin clears the read-out and conversion logic
    if (st.s2[AI_RST]) begin
      next_st.busy = 1'b0;
      next_st.busy_cnt = '0;
      next_st.hold = '0;
      next_st.hold_ch = '0;
      next_st.sh_a = '0;
      next_st.sh_b = '0;
      next_st.load_b = 1'b0;
      next_st.pin_out = '0;
      next_st.pin_oe = '0;
      next_st.marker = 1'b1;
      pop_ready = 1'b0;
    end
  end

  assign push_valid = psel_i && penable_i && st.pready && pwrite_i && paddr_i == REG_RESULT;
  assign push_data = {pwdata_i[RESULT_CH_LSB +: CH_W], pwdata_i[RES_W-1:0]};

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata_o = st.prdata;
  assign pready_o = st.pready;
  assign pslverr_o = st.pslverr;
  assign data_pin_o = st.pin_out;
  assign data_pin_oe_o = st.pin_oe;
  assign first_channel_marker_o = st.marker;
  assign busy_o = st.busy;
  assign power_state_o = st.pwr;
  assign range_10v_o = st.range_10v;
  assign oversample_o = st.os;
  assign ref_internal_en_o = st.ref_en;
  assign reference_pin_oe_o = st.ref_en;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  word_map_a: assert property (st.mode == IF_WORD && data_pin_oe_o[PIN_BYTE] |->
    data_pin_o == {st.hold, 2'b00}) else $error("word mode pin map wrong");
  byte_map_a: assert property (st.mode == IF_BYTE && data_pin_oe_o[PIN_SER_A] |->
    data_pin_o[7:5] == ($past(st.s2[AI_D14]) ? st.hold[13:11] : st.hold[5:3]))
    else $error("byte mode pin map wrong");
  byte_inputs_a: assert property (st.mode == IF_BYTE |->
    data_pin_oe_o[PIN_BYTE:PIN_HBEN] == 2'b00) else $error("byte control pins driven");
  serial_out_a: assert property (st.mode == IF_SERIAL && data_pin_oe_o[PIN_SER_A] |->
    data_pin_o[PIN_SER_A] == st.sh_a[RES_W-1] && data_pin_o[PIN_SER_B] == st.sh_b[RES_W-1])
    else $error("serial outputs wrong");
  first_marker_a: assert property (!$past(st.s2[AI_RST]) |->
    first_channel_marker_o == (st.hold_ch == FIRST_CH)) else $error("marker wrong");
  busy_len_a: assert property ($rose(busy_o) |-> st.busy_cnt ==
    (($past(st.conv_cycles) == '0) ? CNT_ONE : $past(st.conv_cycles)))
    else $error("busy count not loaded");
  busy_end_a: assert property (busy_o && st.busy_cnt == CNT_ONE && !st.s2[AI_RST] |=>
    !busy_o) else $error("busy did not end");
  power_down_a: assert property (!st.s2[AI_PD] |=> power_state_o != PWR_ACTIVE ##0
    range_10v_o == $past(range_10v_o)) else $error("powerdown not honoured");
  drive_gate_a: assert property ((|data_pin_oe_o) && st.mode != IF_SERIAL |->
    $past(!st.s2[AI_CS] && !st.s2[AI_RD])) else $error("pins driven outside read");
  reset_pin_a: assert property ($past(st.s2[AI_RST]) |-> !busy_o && data_pin_oe_o == '0)
    else $error("reset pin did not clear");
  ref_follow_a: assert property (ref_internal_en_o == $past(st.s2[AI_REF]) &&
    reference_pin_oe_o == ref_internal_en_o) else $error("reference select wrong");

  word_read_c: cover property (st.mode == IF_WORD && pop_ready);
  byte_read_c: cover property (st.mode == IF_BYTE && data_pin_oe_o[0] && data_pin_i[PIN_HBEN]);
  serial_frame_c: cover property (st.mode == IF_SERIAL && st.load_b ##1 pop_ready);
  busy_run_c: cover property ($rose(busy_o) ##[1:300] $fell(busy_o));
endmodule

// [verif/arp_host_model.sv]
// host controller model that strobes and reads the result pins
module arp_host_model (
  // strobes toward the device
  output logic rd_sclk_n_o,
  output logic cs_n_o,
  // host drive of the shared data pins
  output logic [15:0] pin_drv_o,
  output logic [15:0] pin_en_o,
  // resolved pin levels and device enables
  input wire logic [15:0] pin_i,
  input wire logic [15:0] oe_i
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    rd_sclk_n_o = 1'h1;
    cs_n_o = 1'h1;
    pin_drv_o = 16'h0000;
    pin_en_o = 16'h0000;
  end

  // one parallel access; byte mode needs pins 14 and 15 set before the strobe
  task automatic par_read(input logic byte_m, input logic hi, output logic [15:0] p,
                          output logic [15:0] o);
    pin_en_o = byte_m ? 16'hC000 : 16'h0000;
    pin_drv_o = {1'h1, hi, 14'h0000};
    #20 cs_n_o = 1'h0;
    rd_sclk_n_o = 1'h0;
    #40 p = pin_i;
    o = oe_i;
    rd_sclk_n_o = 1'h1;
    cs_n_o = 1'h1;
    #40 pin_en_o = 16'h0000;
  endtask

  // serial frame: clock idles high and stands still outside the frame
  task automatic ser_read(output logic [13:0] a, output logic [13:0] b);
    #20 cs_n_o = 1'h0;
    #40;
    // sample a half period after each rising edge, once the shift has settled
    for (int i = 13; i >= 0; i--) begin
      #32 rd_sclk_n_o = 1'h0;
      a[i] = pin_i[7];
      b[i] = pin_i[8];
      #32 rd_sclk_n_o = 1'h1;
    end
    cs_n_o = 1'h1;
    #40;
  endtask
endmodule

// [verif/tb_adc_result_readout_port.sv]
// self-checking bench of the result read-out port
module tb_adc_result_readout_port
  import arp_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  // ********
  // signals
  // ********
  logic clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [ADDR_W-1:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rdat;
  logic rd_sclk_n_i, cs_n_i, rerr, done;
  logic [1:0] interface_select_i, power_state_o;
  logic conv_start_first_half_i, conv_start_second_half_i, powerdown_n_i, range_i;
  logic oversample_ctrl_0_i, oversample_ctrl_1_i, oversample_ctrl_2_i;
  logic reference_select_i, reset_i, first_channel_marker_o, busy_o, range_10v_o;
  logic ref_internal_en_o, reference_pin_oe_o;
  logic [2:0] oversample_o;
  logic [15:0] data_pin_i, data_pin_o, data_pin_oe_o, drv, en, p, o;
  logic [13:0] res [9];
  logic [13:0] sa, sb;
  int errors = 0;
  int num_checks = 0;

  // undriven pins show the inverse of the last level, not a held value
  assign data_pin_i = (data_pin_oe_o & data_pin_o) | (~data_pin_oe_o & en & drv) |
                      (~data_pin_oe_o & ~en & ~data_pin_o);

  arp_port #(.DEPTH(FIFO_DEPTH)) dut_u (
    .clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .rd_sclk_n_i, .cs_n_i, .interface_select_i,
    .conv_start_first_half_i, .conv_start_second_half_i, .powerdown_n_i, .range_i,
    .oversample_ctrl_0_i, .oversample_ctrl_1_i, .oversample_ctrl_2_i, .reference_select_i,
    .reset_i, .data_pin_i, .data_pin_o, .data_pin_oe_o, .first_channel_marker_o, .busy_o,
    .power_state_o, .range_10v_o, .oversample_o, .ref_internal_en_o, .reference_pin_oe_o
  );

  arp_host_model host_u (
    .rd_sclk_n_o(rd_sclk_n_i),
    .cs_n_o(cs_n_i),
    .pin_drv_o(drv),
    .pin_en_o(en),
    .pin_i(data_pin_i),
    .oe_i(data_pin_oe_o)
  );

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  // ********
  // tasks
  // ********
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'h1;
    penable_i <= 1'h0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'h1;
    // look at settled outputs mid-cycle; the next rising edge is the one that takes them
    @(negedge clk_i);
    while (pready_o !== 1'h1 && n < 500) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 500) errors++;
    rdat = prdata_o;
    rerr = pslverr_o;
    @(posedge clk_i);
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask

  task automatic push(input int i);
    apb(1'h1, REG_RESULT, {13'h0000, i[2:0], 2'h0, res[i]});
  endtask

  task automatic wread(input int i);
    host_u.par_read(1'h0, 1'h0, p, o);
    check(p, {res[i], 2'h0});
    check(o, 16'hFFFF);
    check(first_channel_marker_o, i[2:0] == FIRST_CH);
    check(data_pin_oe_o, 16'h0000);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ********
  // tests
  // ********
  initial begin
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {conv_start_first_half_i, conv_start_second_half_i, range_i, reset_i} = '0;
    {oversample_ctrl_2_i, oversample_ctrl_1_i, oversample_ctrl_0_i} = 3'h0;
    reference_select_i = 1'h0;
    powerdown_n_i = 1'h1;
    interface_select_i = IF_WORD;
    done = 1'h0;
    for (int i = 0; i < 9; i++) res[i] = 14'h2A5C + i * 14'h0123;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'h1;
    repeat (4) @(posedge clk_i);
    apb(1'h0, REG_CTRL, 32'h0);
    check(rdat, {16'h0000, CONV_CYCLES_RST});
    apb(1'h0, 8'h40, 32'h0);
    check(rerr, 1'h1);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      powerdown_n_i <= i[1];
      range_i <= i[0] ^ i[1];
      repeat (8) @(posedge clk_i);
      check(power_state_o, i[1] ? PWR_ACTIVE : (i[0] ? PWR_SHUTDOWN : PWR_STANDBY));
      if (i[1]) check(range_10v_o, i[0] ^ i[1]);
    end
    for (int i = 0; i < 8; i++) begin
      {oversample_ctrl_2_i, oversample_ctrl_1_i, oversample_ctrl_0_i} <= i[2:0];
      reference_select_i <= i[0];
      repeat (6) @(posedge clk_i);
      check(oversample_o, i[2:0]);
      check({ref_internal_en_o, reference_pin_oe_o}, {2{i[0]}});
    end
    $display("test power and pins done");
    apb(1'h1, REG_CTRL, 32'h14);
    conv_start_first_half_i <= 1'h1;
    repeat (8) @(posedge clk_i);
    check(busy_o, 1'h1);
    conv_start_first_half_i <= 1'h0;
    repeat (30) @(posedge clk_i);
    check(busy_o, 1'h0);
    push(0);
    conv_start_second_half_i <= 1'h1;
    repeat (8) @(posedge clk_i);
    check(busy_o, 1'h1);
    conv_start_second_half_i <= 1'h0;
    reset_i <= 1'h1;
    repeat (8) @(posedge clk_i);
    check(busy_o, 1'h0);
    reset_i <= 1'h0;
    repeat (6) @(posedge clk_i);
    apb(1'h0, REG_STATUS, 32'h0);
    check(rdat[19:16], 4'h0);
    $display("test busy and reset done");
    for (int i = 0; i < 8; i++) push(i);
    apb(1'h0, REG_STATUS, 32'h0);
    check(rdat[19:16], 4'h8);
    fork
      begin
        push(8);
        done = 1'h1;
      end
      begin
        repeat (20) @(posedge clk_i);
        check(done, 1'h0);
        wread(0);
      end
    join
    for (int i = 1; i < 9; i++) wread(i);
    apb(1'h0, REG_STATUS, 32'h0);
    check(rdat[19:16], 4'h0);
    $display("test word mode and buffer done");
    interface_select_i <= IF_BYTE;
    push(2);
    host_u.par_read(1'h1, 1'h1, p, o);
    check(p[7:0], res[2][13:6]);
    check(o[15:14], 2'h0);
    host_u.par_read(1'h1, 1'h0, p, o);
    check(p[7:0], {res[2][5:0], 2'h0});
    $display("test byte mode done");
    interface_select_i <= IF_SERIAL;
    push(3);
    push(4);
    host_u.ser_read(sa, sb);
    check(sa, res[3]);
    check(sb, res[4]);
    $display("test serial mode done");
    close_out();
  end

  // limit is far above the few microseconds the tests take
  initial begin
    #100000;
    errors++;
    $display("watchdog expired");
    close_out();
  end
endmodule
